// file: inc/prm_map.svh
/*
 Register offsets, field positions, reset values and widths of the pin routing unit.
 Assumes an 8-bit register port with 16-bit byte addresses.
*/
`ifndef PRM_MAP_SVH
`define PRM_MAP_SVH

`define PRM_ADDR_W      16
`define PRM_DATA_W      8

`define PRM_ADDR_DATA_A 16'h0220
`define PRM_ADDR_DATA_B 16'h0221
`define PRM_ADDR_IN_A   16'h0222
`define PRM_ADDR_IN_B   16'h0223
`define PRM_ADDR_DIR_A  16'h0224
`define PRM_ADDR_DIR_B  16'h0225
`define PRM_ADDR_RED_C  16'h025a
`define PRM_ADDR_RED_D  16'h025b
`define PRM_ADDR_IN_C   16'h0230
`define PRM_ADDR_IN_D   16'h0231
`define PRM_ADDR_OWN_A  16'h0232

`define PRM_RST_DATA    8'h00
`define PRM_RST_DIR     8'h00
`define PRM_RST_RED     8'h00

`define PRM_PA_TRACE_DATA 7
`define PRM_PA_TRACE_CLK  6
`define PRM_PA_CAN_TX     5
`define PRM_PA_CAN_RX     4
`define PRM_PC_LINK_CLK   0
`define PRM_PC_LINK_INT   1

`define PRM_PB_W        2
`define PRM_PC_W        2
`define PRM_SPI_W       4
`define PRM_DL_W        8
`define PRM_DL_NARROW   4

`endif

// file: inc/prm_pkg.sv
/*
 Types of the pin routing unit.
 Assumes prm_map.svh is on the include path.
*/
`include "prm_map.svh"

package prm_pkg;

	typedef logic [`PRM_DATA_W-1:0] prm_byte_type;
	typedef logic [`PRM_ADDR_W-1:0] prm_addr_type;

	typedef struct packed {
		prm_byte_type data_a;
		logic [`PRM_PB_W-1:0] data_b;
		prm_byte_type dir_a;
		logic [`PRM_PB_W-1:0] dir_b;
		logic red_c;
		prm_byte_type red_d;
		prm_byte_type in_a;
		logic [`PRM_PB_W-1:0] in_b;
		logic [`PRM_PC_W-1:0] in_c;
		prm_byte_type in_d;
		logic mode;
		prm_byte_type rdata;
	} prm_state_type;

endpackage

// file: core/prm_link_pads.sv
/*
 Pad steering for the die link: port C clock and interrupt, port D data.
 Assumes the link controller and reduced-drive bits come from the routing unit.
*/
`timescale 1ns/1ps
`include "prm_map.svh"

module prm_link_pads (
	input  wire logic                  link_wide,
	input  wire logic                  link_clk,
	input  wire logic [`PRM_DL_W-1:0]  link_data_out,
	input  wire logic                  link_drive,
	input  wire logic                  red_c,
	input  wire logic [`PRM_DL_W-1:0]  red_d,
	input  wire logic [`PRM_PC_W-1:0]  pc_in,
	input  wire logic [`PRM_DL_W-1:0]  pd_in,
	output logic      [`PRM_PC_W-1:0]  pc_out,
	output logic      [`PRM_PC_W-1:0]  pc_oe_n,
	output logic      [`PRM_PC_W-1:0]  pc_pulldown,
	output logic      [`PRM_PC_W-1:0]  pc_reduced,
	output logic      [`PRM_DL_W-1:0]  pd_out,
	output logic      [`PRM_DL_W-1:0]  pd_oe_n,
	output logic      [`PRM_DL_W-1:0]  pd_pulldown,
	output logic      [`PRM_DL_W-1:0]  pd_reduced,
	output logic      [`PRM_DL_W-1:0]  link_data_in,
	output logic                       link_int_in
);

	logic [`PRM_DL_W-1:0] used;

	always_comb begin
		used = '1;
		if (!link_wide) begin
			used = {{(`PRM_DL_W-`PRM_DL_NARROW){1'b0}}, {`PRM_DL_NARROW{1'b1}}};
		end
		pc_out = '0;
		pc_out[`PRM_PC_LINK_CLK] = link_clk;
		pc_oe_n = '1;
		pc_oe_n[`PRM_PC_LINK_CLK] = 1'b0;
		pc_pulldown = '0;
		pc_pulldown[`PRM_PC_LINK_INT] = 1'b1;
		pc_reduced = '0;
		pc_reduced[`PRM_PC_LINK_CLK] = red_c;
		link_int_in = pc_in[`PRM_PC_LINK_INT];
		pd_out = link_data_out & used;
		pd_oe_n = ~(used & {`PRM_DL_W{link_drive}});
		// Idle upper lines stay pulled down so they never float
		pd_pulldown = pd_oe_n;
		pd_reduced = red_d;
		link_data_in = pd_in & used;
	end

endmodule

// file: core/prm_port_mux.sv
/*
 Pin routing unit: priority and multiplexing of ports A to D, GPIO registers,
 input sampling, die-link pad options and debug-pin mode capture.
 Assumes pins and peripheral signals are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "prm_map.svh"

// Operation
// - Shared pin goes to its highest-priority enabled function.
// - Ports A and B fall back to GPIO when no function claims them.
// - Peripheral outputs steered to pins, pin inputs steered to owners.
// - Port A: SPI bits 3-0, CAN rx/tx 4/5, trace 6/7, event on 7.
// - Port B pins serve the oscillator ahead of GPIO.
// - Port C bit 0 drives the die-link clock out.
// - Port C bit 1 is the die-link interrupt input from the companion.
// - Port D pin n carries die-link data bit n, bidirectional.
// - Die-link data is 8 or 4 bits wide; narrow uses low lines.
// - Die-link input pins enable pull-downs while acting as inputs.
// - Link clock and port D pins have per-pin reduced-drive bits.
// - Data registers for ports A and B drive GPIO outputs.
// - Direction registers for ports A and B select GPIO in or out.
// - Read-only input registers for all four ports return pin levels.
// - Debug pin is mode select during reset, debug link afterwards.
// - Input registers follow the pin whoever owns it.
module prm_port_mux
	import prm_pkg::*;
(
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	input  wire prm_pkg::prm_addr_type  addr,
	input  wire prm_pkg::prm_byte_type  wdata,
	input  wire logic                   wr_strobe,
	input  wire logic                   rd_strobe,
	output prm_pkg::prm_byte_type       rdata,
	input  wire logic                   spi_enable,
	input  wire logic [`PRM_SPI_W-1:0]  spi_out,
	input  wire logic [`PRM_SPI_W-1:0]  spi_drive,
	output logic      [`PRM_SPI_W-1:0]  spi_in,
	input  wire logic                   can_tx_enable,
	input  wire logic                   can_transmit_line,
	input  wire logic                   can_rx_enable,
	output logic                        can_receive_line,
	input  wire logic                   trace_enable,
	input  wire logic                   trace_data_out,
	input  wire logic                   trace_clock_out,
	input  wire logic                   event_enable,
	output logic                        debug_event_in,
	input  wire logic                   osc_enable,
	input  wire logic                   debug_out,
	input  wire logic                   debug_drive,
	output logic                        debug_in,
	output logic                        mode_select_input,
	input  wire logic                   link_wide,
	input  wire logic                   link_clk,
	input  wire logic [`PRM_DL_W-1:0]   link_data_out,
	input  wire logic                   link_drive,
	output logic      [`PRM_DL_W-1:0]   link_data_in,
	output logic                        die_link_interrupt_in,
	input  wire logic [`PRM_DATA_W-1:0] pa_in,
	output logic      [`PRM_DATA_W-1:0] pa_out,
	output logic      [`PRM_DATA_W-1:0] pa_oe_n,
	input  wire logic [`PRM_PB_W-1:0]   pb_in,
	output logic      [`PRM_PB_W-1:0]   pb_out,
	output logic      [`PRM_PB_W-1:0]   pb_oe_n,
	output logic                        pb_osc_owned,
	input  wire logic [`PRM_PC_W-1:0]   pc_in,
	output logic      [`PRM_PC_W-1:0]   pc_out,
	output logic      [`PRM_PC_W-1:0]   pc_oe_n,
	output logic      [`PRM_PC_W-1:0]   pc_pulldown,
	output logic      [`PRM_PC_W-1:0]   pc_reduced,
	input  wire logic [`PRM_DL_W-1:0]   pd_in,
	output logic      [`PRM_DL_W-1:0]   pd_out,
	output logic      [`PRM_DL_W-1:0]   pd_oe_n,
	output logic      [`PRM_DL_W-1:0]   pd_pulldown,
	output logic      [`PRM_DL_W-1:0]   pd_reduced,
	input  wire logic                   debug_pin_in,
	output logic                        debug_pin_out,
	output logic                        debug_pin_oe_n
);

	import prm_pkg::*;

	prm_state_type state;
	prm_state_type next_state;

	logic [`PRM_DATA_W-1:0] fn_own;
	logic [`PRM_DATA_W-1:0] fn_drive;
	logic [`PRM_DATA_W-1:0] fn_val;

	// Data register reads back the pin when the bit is an input
	function automatic prm_byte_type gpio_view(
		input prm_byte_type data,
		input prm_byte_type dir,
		input prm_byte_type pins
	);
		gpio_view = (dir & data) | (~dir & pins);
	endfunction

	function automatic prm_byte_type read_mux(
		input prm_state_type s,
		input prm_addr_type  a,
		input prm_byte_type  own
	);
		prm_byte_type b_data;
		prm_byte_type b_dir;
		prm_byte_type b_in;
		b_data = {{(`PRM_DATA_W-`PRM_PB_W){1'b0}}, s.data_b};
		b_dir  = {{(`PRM_DATA_W-`PRM_PB_W){1'b0}}, s.dir_b};
		b_in   = {{(`PRM_DATA_W-`PRM_PB_W){1'b0}}, s.in_b};
		unique case (a)
			`PRM_ADDR_DATA_A: read_mux = gpio_view(s.data_a, s.dir_a, s.in_a);
			`PRM_ADDR_DATA_B: read_mux = gpio_view(b_data, b_dir, b_in);
			`PRM_ADDR_IN_A:   read_mux = s.in_a;
			`PRM_ADDR_IN_B:   read_mux = b_in;
			`PRM_ADDR_IN_C:   read_mux = {{(`PRM_DATA_W-`PRM_PC_W){1'b0}}, s.in_c};
			`PRM_ADDR_IN_D:   read_mux = s.in_d;
			`PRM_ADDR_DIR_A:  read_mux = s.dir_a;
			`PRM_ADDR_DIR_B:  read_mux = b_dir;
			`PRM_ADDR_RED_C:  read_mux = {{(`PRM_DATA_W-1){1'b0}}, s.red_c};
			`PRM_ADDR_RED_D:  read_mux = s.red_d;
			`PRM_ADDR_OWN_A:  read_mux = own;
			// Unmapped and reserved locations read as zero
			default:          read_mux = 8'h00;
		endcase
	endfunction

	// Port A claims, highest priority first per pin
	always_comb begin
		fn_own   = {trace_enable | event_enable, trace_enable, can_tx_enable,
			can_rx_enable, {`PRM_SPI_W{spi_enable}}};
		fn_drive = {trace_enable, trace_enable, can_tx_enable, 1'b0,
			spi_drive & {`PRM_SPI_W{spi_enable}}};
		fn_val   = {trace_data_out, trace_clock_out, can_transmit_line, 1'b0,
			spi_out};
	end

	// Pin steering stays combinational so a new owner acts at once
	always_comb begin
		pa_out  = (fn_own & fn_val) | (~fn_own & state.data_a);
		pa_oe_n = (fn_own & ~fn_drive) | (~fn_own & ~state.dir_a);
		pb_osc_owned = osc_enable;
		pb_out  = osc_enable ? '0 : state.data_b;
		pb_oe_n = osc_enable ? '1 : ~state.dir_b;
	end

	// Pin levels back to the owning peripheral only
	always_comb begin
		spi_in = spi_enable ? pa_in[`PRM_SPI_W-1:0] : '0;
		can_receive_line = can_rx_enable ? pa_in[`PRM_PA_CAN_RX] : 1'b1;
		debug_event_in = (event_enable & ~trace_enable) ?
			pa_in[`PRM_PA_TRACE_DATA] : 1'b0;
	end

	// Debug pin never drives while reset holds it as a strap
	always_comb begin
		debug_pin_out  = debug_out;
		debug_pin_oe_n = reset | ~debug_drive;
		debug_in       = reset ? 1'b1 : debug_pin_in;
		mode_select_input = state.mode;
	end

	prm_link_pads u_link (
		.link_wide     (link_wide),
		.link_clk      (link_clk),
		.link_data_out (link_data_out),
		.link_drive    (link_drive),
		.red_c         (state.red_c),
		.red_d         (state.red_d),
		.pc_in         (pc_in),
		.pd_in         (pd_in),
		.pc_out        (pc_out),
		.pc_oe_n       (pc_oe_n),
		.pc_pulldown   (pc_pulldown),
		.pc_reduced    (pc_reduced),
		.pd_out        (pd_out),
		.pd_oe_n       (pd_oe_n),
		.pd_pulldown   (pd_pulldown),
		.pd_reduced    (pd_reduced),
		.link_data_in  (link_data_in),
		.link_int_in   (die_link_interrupt_in)
	);

	always_comb begin
		next_state = state;
		// Inputs sampled every cycle regardless of owner
		next_state.in_a = pa_in;
		next_state.in_b = pb_in;
		next_state.in_c = pc_in;
		next_state.in_d = pd_in;
		next_state.rdata = 8'h00;
		if (rd_strobe) begin
			next_state.rdata = read_mux(state, addr, fn_own);
		end
		if (wr_strobe) begin
			unique case (addr)
				`PRM_ADDR_DATA_A: next_state.data_a = wdata;
				`PRM_ADDR_DATA_B: next_state.data_b = wdata[`PRM_PB_W-1:0];
				`PRM_ADDR_DIR_A:  next_state.dir_a = wdata;
				`PRM_ADDR_DIR_B:  next_state.dir_b = wdata[`PRM_PB_W-1:0];
				`PRM_ADDR_RED_C:  next_state.red_c = wdata[0];
				`PRM_ADDR_RED_D:  next_state.red_d = wdata;
				// Input registers and the rest ignore writes
				default: ;
			endcase
		end
		// Strap follows the pin for as long as reset stays high
		next_state.mode = reset ? debug_pin_in : state.mode;
		if (reset) begin
			next_state.data_a = `PRM_RST_DATA;
			next_state.data_b = `PRM_PB_W'(`PRM_RST_DATA);
			next_state.dir_a  = `PRM_RST_DIR;
			next_state.dir_b  = `PRM_PB_W'(`PRM_RST_DIR);
			next_state.red_c  = 1'b0;
			next_state.red_d  = `PRM_RST_RED;
			next_state.rdata  = 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		state <= next_state;
	end

	assign rdata = state.rdata;

endmodule

// file: testbench/prm_port_mux_chk.sv
/*
 Checker for the pin routing unit top module.
 Assumes it is bound to prm_port_mux and sees only its ports.
*/
`timescale 1ns/1ps
`include "prm_map.svh"
module prm_port_mux_chk
	import prm_pkg::*;
(
	input wire logic                  ref_clk,
	input wire logic                  reset,
	input wire logic                  rd_strobe,
	input wire logic                  spi_enable,
	input wire logic                  trace_enable,
	input wire logic                  trace_data_out,
	input wire logic                  can_rx_enable,
	input wire logic                  osc_enable,
	input wire logic                  link_clk,
	input wire logic                  debug_pin_in,
	input wire logic                  debug_pin_oe_n,
	input wire logic                  mode_select_input,
	input wire logic                  can_receive_line,
	input wire logic                  die_link_interrupt_in,
	input wire logic                  debug_event_in,
	input wire prm_pkg::prm_addr_type addr,
	input wire prm_pkg::prm_byte_type rdata,
	input wire logic [7:0]            pa_in,
	input wire logic [7:0]            pa_out,
	input wire logic [7:0]            pa_oe_n,
	input wire logic [7:0]            pd_oe_n,
	input wire logic [7:0]            pd_pulldown,
	input wire logic [3:0]            spi_out,
	input wire logic [3:0]            spi_drive,
	input wire logic [1:0]            pb_oe_n,
	input wire logic [1:0]            pc_in,
	input wire logic [1:0]            pc_out,
	input wire logic [1:0]            pc_oe_n,
	input wire logic [1:0]            pc_pulldown
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence rd_in_a;
		rd_strobe && addr == `PRM_ADDR_IN_A;
	endsequence
	a_spi_pin_steer: assert property (spi_enable |-> pa_out[3:0] == spi_out
		&& pa_oe_n[3:0] == ~spi_drive) else $error("spi pins not steered");
	a_trace_over_event: assert property (trace_enable |-> !pa_oe_n[7]
		&& pa_out[7] == trace_data_out && !debug_event_in) else $error("pin 7 priority");
	a_can_rx_route: assert property (can_receive_line
		== (can_rx_enable ? pa_in[4] : 1'b1)) else $error("can receive route");
	a_link_int_in: assert property (die_link_interrupt_in == pc_in[1]
		&& pc_oe_n[1] && pc_pulldown[1]) else $error("link interrupt pin");
	a_link_clk_out: assert property (!pc_oe_n[0] && pc_out[0] == link_clk)
		else $error("link clock pin");
	a_pd_pulldown: assert property (pd_pulldown == pd_oe_n)
		else $error("port d pull-down");
	a_osc_release: assert property (osc_enable |-> pb_oe_n == 2'b11)
		else $error("oscillator pins driven");
	a_input_read: assert property (rd_in_a |=> rdata == $past(pa_in, 2))
		else $error("input read value");
	a_rdata_idle: assert property (!rd_strobe |=> rdata == 8'h00)
		else $error("read data held");
	a_mode_capture: assert property (disable iff (1'b0) $fell(reset)
		|-> mode_select_input == $past(debug_pin_in)) else $error("mode capture");
	a_debug_released: assert property (disable iff (1'b0) reset |-> debug_pin_oe_n)
		else $error("debug pin driven in reset");
endmodule
bind prm_port_mux prm_port_mux_chk chk_u (.*);

// file: testbench/prm_pin_model.sv
/*
 Far side: external port A pins, companion die on ports C and D.
 Assumes the bench sets what the outside drives.
*/
`timescale 1ns/1ps
module prm_pin_model (
	input  wire logic       ref_clk,
	input  wire logic       ext_d_en,
	input  wire logic       ext_int,
	input  wire logic [7:0] pa_out,
	input  wire logic [7:0] pa_oe_n,
	input  wire logic [7:0] ext_a,
	input  wire logic [7:0] pd_out,
	input  wire logic [7:0] pd_oe_n,
	input  wire logic [7:0] pd_pulldown,
	input  wire logic [7:0] ext_d,
	input  wire logic [1:0] pc_out,
	input  wire logic [1:0] pc_oe_n,
	output logic      [7:0] pa_in,
	output logic      [7:0] pd_in,
	output logic      [1:0] pc_in
);
	logic [7:0] last_d = 8'h00;
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			pa_in[k] = pa_oe_n[k] ? ext_a[k] : pa_out[k];
			// Floating lane without pull-down shows the inverse, not a stale value
			pd_in[k] = !pd_oe_n[k] ? pd_out[k] : ext_d_en ? ext_d[k]
				: pd_pulldown[k] ? 1'b0 : ~last_d[k];
		end
		pc_in[0] = pc_out[0] ^ pc_oe_n[0];
		pc_in[1] = ext_int;
	end
	always_ff @(posedge ref_clk) begin
		last_d <= pd_in;
	end
endmodule

// file: testbench/test_port_pin_function_mux.sv
/*
 Self-checking bench of the pin routing unit.
 Assumes the checker is bound and the pin model stands for the far side.
*/
`timescale 1ns/1ps
`include "prm_map.svh"
module test_port_pin_function_mux;
	import prm_pkg::*;
	logic ref_clk, reset, wr_strobe, rd_strobe, spi_enable, can_tx_enable, can_transmit_line;
	logic can_rx_enable, can_receive_line, trace_enable, trace_data_out, trace_clock_out;
	logic event_enable, debug_event_in, osc_enable, debug_out, debug_drive, debug_in;
	logic mode_select_input, link_wide, link_clk, link_drive, die_link_interrupt_in;
	logic pb_osc_owned, debug_pin_in, debug_pin_out, debug_pin_oe_n, ext_d_en, ext_int;
	prm_addr_type addr;
	prm_byte_type wdata, rdata, pa_in, pa_out, pa_oe_n, link_data_out, link_data_in, pd_in;
	prm_byte_type pd_out, pd_oe_n, pd_pulldown, pd_reduced, ext_a, ext_d, m_data, m_dir, m_pin;
	prm_byte_type m_e, m_o;
	logic [3:0] spi_out, spi_drive, spi_in;
	logic [1:0] pb_in, pb_out, pb_oe_n, pc_in, pc_out, pc_oe_n, pc_pulldown, pc_reduced, m_db;
	logic [1:0] m_bd, m_eb;
	logic [31:0] lfsr = 32'h00013e7d;
	int err_count = 0, cmp_count = 0, cyc = 0;
	prm_port_mux dut_u (.*);
	prm_pin_model far_u (.*);
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Whole run needs well under a thousand cycles
	always @(posedge ref_clk) if (++cyc == 4000) begin
		err_count++;
		complete_run();
	end
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input prm_addr_type a, input prm_byte_type d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_strobe <= 1'b1;
		@(posedge ref_clk);
		wr_strobe <= 1'b0;
	endtask
	task automatic rd(input prm_addr_type a, input prm_byte_type e);
		@(posedge ref_clk);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge ref_clk);
		rd_strobe <= 1'b0;
		#1 cmp(rdata, e);
	endtask
	task automatic chk_a;
		m_e = ~m_dir;
		m_o = m_data;
		m_eb = osc_enable ? 2'b11 : ~m_db;
		if (spi_enable) begin
			m_e[3:0] = ~spi_drive;
			m_o[3:0] = spi_out;
		end
		if (can_rx_enable) m_e[4] = 1'b1;
		if (can_tx_enable) {m_e[5], m_o[5]} = {1'b0, can_transmit_line};
		if (trace_enable) {m_e[7:6], m_o[7:6]} = {2'b00, trace_data_out, trace_clock_out};
		else if (event_enable) m_e[7] = 1'b1;
		m_pin = (m_o & ~m_e) | (ext_a & m_e);
		cmp(pa_oe_n, m_e);
		cmp(pa_out & ~m_e, m_o & ~m_e);
		cmp({debug_event_in, can_receive_line, spi_in}, {event_enable && !trace_enable &&
			m_pin[7], can_rx_enable ? m_pin[4] : 1'b1, spi_enable ? m_pin[3:0] : 4'h0});
		cmp({pb_osc_owned, pb_oe_n}, osc_enable ? 3'h7 : {1'b0, ~m_db});
		cmp({6'h00, pb_out & ~m_eb}, {6'h00, m_bd & ~m_eb});
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		{wr_strobe, rd_strobe, spi_enable, can_tx_enable, can_transmit_line, can_rx_enable,
			trace_enable, trace_data_out, trace_clock_out, event_enable, osc_enable, debug_out,
			debug_drive, link_wide, link_clk, link_drive, ext_d_en, ext_int, addr, wdata,
			spi_out, spi_drive, link_data_out, pb_in, ext_a, ext_d, m_data, m_dir, m_db, m_bd} = '0;
		reset = 1'b1;
		debug_pin_in = 1'b1;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1 cmp(mode_select_input, 1'b1);
		chk_a();
		rd(`PRM_ADDR_DIR_A, 8'h00);
		rd(`PRM_ADDR_RED_D, 8'h00);
		for (int n = 0; n < 9; n++) begin
			lfsr = step(lfsr);
			{m_bd, m_db, m_dir, m_data} = lfsr[19:0];
			wr(`PRM_ADDR_DATA_A, m_data);
			wr(`PRM_ADDR_DATA_B, {6'h00, m_bd});
			wr(`PRM_ADDR_DIR_A, m_dir);
			wr(`PRM_ADDR_DIR_B, {6'h00, m_db});
			{spi_enable, can_tx_enable, can_transmit_line, can_rx_enable, trace_enable,
				trace_data_out, trace_clock_out, event_enable, osc_enable, spi_out,
				spi_drive} <= (n == 8) ? 17'h0 : lfsr[31:15];
			ext_a <= ~lfsr[7:0];
			link_clk <= lfsr[3];
			pb_in <= lfsr[5:4];
			repeat (2) @(posedge ref_clk);
			#1 chk_a();
			rd(`PRM_ADDR_DATA_A, (m_data & m_dir) | (m_pin & ~m_dir));
			rd(`PRM_ADDR_DATA_B, {6'h00, (m_bd & m_db) | (pb_in & ~m_db)});
			rd(`PRM_ADDR_IN_A, m_pin);
			rd(`PRM_ADDR_IN_B, {6'h00, pb_in});
			rd(`PRM_ADDR_OWN_A, {trace_enable | event_enable, trace_enable,
				can_tx_enable, can_rx_enable, {4{spi_enable}}});
		end
		wr(`PRM_ADDR_IN_A, ~m_pin);
		rd(`PRM_ADDR_IN_A, m_pin);
		rd(16'h0300, 8'h00);
		for (int i = 0; i < 4; i++) begin
			lfsr = step(lfsr);
			wr(`PRM_ADDR_RED_D, lfsr[7:0]);
			wr(`PRM_ADDR_RED_C, {7'h00, lfsr[8]});
			{link_drive, link_wide} <= i[1:0];
			ext_d_en <= !i[1];
			{ext_int, ext_d, link_data_out} <= lfsr[24:8];
			{debug_drive, debug_out, debug_pin_in} <= lfsr[27:25];
			repeat (2) @(posedge ref_clk);
			m_e = i[1] ? (i[0] ? 8'h00 : 8'hf0) : 8'hff;
			m_pin = (lfsr[15:8] & ~m_e) | (i[1] ? 8'h00 : lfsr[23:16]);
			#1 cmp(pd_oe_n, m_e);
			cmp(pd_pulldown, m_e);
			cmp(pd_out & ~m_e, lfsr[15:8] & ~m_e);
			cmp(pd_in, m_pin);
			cmp(link_data_in, m_pin & (i[0] ? 8'hff : 8'h0f));
			cmp(pd_reduced, lfsr[7:0]);
			cmp({6'h00, pc_reduced}, {7'h00, lfsr[8]});
			cmp(die_link_interrupt_in, lfsr[24]);
			cmp({debug_pin_oe_n, debug_pin_out, debug_in},
				{~lfsr[27], lfsr[26], lfsr[25]});
			rd(`PRM_ADDR_IN_D, m_pin);
			rd(`PRM_ADDR_IN_C, {6'h00, lfsr[24], link_clk});
		end
		@(posedge ref_clk);
		debug_pin_in <= 1'b0;
		debug_drive <= 1'b1;
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 cmp({debug_pin_oe_n, debug_in}, 2'b11);
		@(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1 cmp(mode_select_input, 1'b0);
		cmp({debug_pin_oe_n, debug_in}, 2'b00);
		{m_bd, m_db, m_dir, m_data} = '0;
		chk_a();
		rd(`PRM_ADDR_DIR_A, 8'h00);
		complete_run();
	end
endmodule
